//--- core/bptv_top.sv
// two-of-three building high pressure trip voter with manual path
`timescale 1ns/1ps
`default_nettype none
module bptv_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire bptv_pkg::bptv_press_t measured_building_pressure_i [bptv_pkg::NUM_CHAN],
    input wire logic [bptv_pkg::NUM_VOTED-1:0] manual_trip_pb_i,
    input wire logic [bptv_pkg::NUM_VOTED-1:0] manual_reset_pb_i,
    input wire logic shared_checkback_i,
    output logic [bptv_pkg::NUM_VOTED-1:0] building_cooling_initiation_o,
    output logic [bptv_pkg::NUM_OTHER-1:0] building_high_pressure_trip_o,
    output logic integrated_control_link_o,
    output logic [bptv_pkg::NUM_CHAN-1:0] chan_trip_status_o,
    output logic [bptv_pkg::NUM_CHAN-1:0] chan_bypass_status_o,
    output logic [bptv_pkg::NUM_CHAN-1:0] sensor_range_fault_o,
    output logic status_update_o,
    output logic odd_checkback_o,
    output logic even_checkback_o
);
    import bptv_pkg::*;

    // contact input synchronisers; only stage two reads stage one
    wire logic [NUM_PINS-1:0] raw_pin;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pin;
    logic [NUM_PINS-1:0] pin_prev;
    logic [NUM_PINS-1:0] next_sync1;
    logic [NUM_PINS-1:0] next_sync2;
    logic [NUM_PINS-1:0] next_sync3;
    logic [NUM_PINS-1:0] next_pin;
    logic [NUM_PINS-1:0] next_pin_prev;

    // pin index map ties each contact to its own filter lane
    assign raw_pin[PIN_TRIP0] = manual_trip_pb_i[0];
    assign raw_pin[PIN_TRIP1] = manual_trip_pb_i[1];
    assign raw_pin[PIN_RESET0] = manual_reset_pb_i[0];
    assign raw_pin[PIN_RESET1] = manual_reset_pb_i[1];
    assign raw_pin[PIN_CHECKBACK] = shared_checkback_i;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            // a change is accepted once stages two and three agree
            always_comb begin
                next_sync1[gp] = raw_pin[gp];
                next_sync2[gp] = sync1[gp];
                next_sync3[gp] = sync2[gp];
                next_pin[gp] = (sync2[gp] == sync3[gp]) ? sync3[gp] : pin[gp];
                next_pin_prev[gp] = pin[gp];
            end
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    sync1[gp] <= PIN_RST;
                    sync2[gp] <= PIN_RST;
                    sync3[gp] <= PIN_RST;
                    pin[gp] <= PIN_RST;
                    pin_prev[gp] <= PIN_RST;
                end else begin
                    sync1[gp] <= next_sync1[gp];
                    sync2[gp] <= next_sync2[gp];
                    sync3[gp] <= next_sync3[gp];
                    pin[gp] <= next_pin[gp];
                    pin_prev[gp] <= next_pin_prev[gp];
                end
            end
        end
    endgenerate

    logic [NUM_VOTED-1:0] trip_pb;
    logic [NUM_VOTED-1:0] reset_press;
    logic any_reset_press;

    assign trip_pb = {pin[PIN_TRIP1], pin[PIN_TRIP0]};
    // a held reset button acts once, on the rising edge of its filtered level
    assign reset_press = {pin[PIN_RESET1] & ~pin_prev[PIN_RESET1],
                          pin[PIN_RESET0] & ~pin_prev[PIN_RESET0]};
    assign any_reset_press = |reset_press;

    // protective channel bistables, one transmitter each
    logic [NUM_CHAN-1:0] tripped;
    logic [NUM_CHAN-1:0] out_of_range;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
            bptv_chan_if link ();
            logic below_span;
            logic above_span;
            assign link.pressure = measured_building_pressure_i[gc];
            // either reset button offers the reset to all three bistables
            assign link.reset_req = any_reset_press;
            assign tripped[gc] = link.tripped;
            // a range flag only reports, it never trips the channel
            assign below_span = (measured_building_pressure_i[gc] < RANGE_MIN_CNT);
            assign above_span = (measured_building_pressure_i[gc] > RANGE_MAX_CNT);
            assign out_of_range[gc] = below_span | above_span;
            bptv_chan u_chan (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .link(link)
            );
        end
    endgenerate

    // automatic two of three vote; no bypass or inhibit term enters here
    logic [NUM_CHAN-1:0] pair_trip;
    logic vote;

    always_comb begin
        // each pair of channels that both stand tripped carries the vote
        pair_trip[0] = tripped[0] & tripped[1];
        pair_trip[1] = tripped[0] & tripped[2];
        pair_trip[2] = tripped[1] & tripped[2];
        vote = |pair_trip;
    end

    // associated actuation: four other channels and the degraded contact
    logic [NUM_OTHER-1:0] next_other;
    logic next_degraded;

    always_comb begin
        // the four other channels follow the voted trip, not a single bistable
        next_other = {NUM_OTHER{vote}};
        next_degraded = tripped[CHAN_A];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            building_high_pressure_trip_o <= {NUM_OTHER{ACT_RST}};
            integrated_control_link_o <= ACT_RST;
        end else begin
            building_high_pressure_trip_o <= next_other;
            integrated_control_link_o <= next_degraded;
        end
    end

    // manual path per voted channel; its latch sees only its own buttons
    logic [NUM_VOTED-1:0] manual_latch;
    logic [NUM_VOTED-1:0] next_manual_latch;
    logic [NUM_VOTED-1:0] next_cooling;

    genvar gv;
    generate
        for (gv = 0; gv < NUM_VOTED; gv++) begin : g_manual
            always_comb begin
                // a held trip button wins over its reset button
                if (trip_pb[gv]) begin
                    next_manual_latch[gv] = 1'h1;
                end else if (reset_press[gv]) begin
                    next_manual_latch[gv] = 1'h0;
                end else begin
                    next_manual_latch[gv] = manual_latch[gv];
                end
            end
        end
    endgenerate

    always_comb begin
        // the button term bypasses the latch, so a stuck latch cannot block it
        next_cooling = {NUM_VOTED{vote}} | next_manual_latch | trip_pb;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            manual_latch <= {NUM_VOTED{ACT_RST}};
            building_cooling_initiation_o <= {NUM_VOTED{ACT_RST}};
        end else begin
            manual_latch <= next_manual_latch;
            building_cooling_initiation_o <= next_cooling;
        end
    end

    // plant computer points: trip state, range flag and a change pulse
    logic [NUM_CHAN-1:0] next_trip_status;
    logic [NUM_CHAN-1:0] next_fault;
    logic next_update;

    always_comb begin
        next_trip_status = tripped;
        next_fault = out_of_range;
        // the pulse rises together with the new status word
        next_update = (next_trip_status != chan_trip_status_o);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            chan_trip_status_o <= {NUM_CHAN{TRIP_RST}};
            sensor_range_fault_o <= {NUM_CHAN{TRIP_RST}};
            status_update_o <= 1'h0;
        end else begin
            chan_trip_status_o <= next_trip_status;
            sensor_range_fault_o <= next_fault;
            status_update_o <= next_update;
        end
    end

    // shared checkback feeds the odd and the even cabinet alike
    logic next_odd_checkback;
    logic next_even_checkback;

    always_comb begin
        next_odd_checkback = pin[PIN_CHECKBACK];
        next_even_checkback = pin[PIN_CHECKBACK];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            odd_checkback_o <= PIN_RST;
            even_checkback_o <= PIN_RST;
        end else begin
            odd_checkback_o <= next_odd_checkback;
            even_checkback_o <= next_even_checkback;
        end
    end

    // bypass status is always reported as not bypassed
    assign chan_bypass_status_o = {NUM_CHAN{1'h0}};
endmodule : bptv_top
`default_nettype wire

//--- core/bptv_pkg.sv
// constants and types for the building pressure trip voter
// Operation
// - each channel trips at pressure at setpoint
// - setpoint 3 psig, below 4 psig limit
// - two of three trips actuate both channels
// - trip also requests actuation channels one-four
// - each manual pushbutton forces its own voted channel
// - manual path works despite automatic failure
// - no bypass or inhibit input exists
// - channel A gives degraded containment contact
// - shared checkback feeds odd and even cabinets
// - trip and bypass status sent to gateway
package bptv_pkg;
    localparam int NUM_CHAN = 3;
    localparam int NUM_VOTED = 2;
    localparam int NUM_OTHER = 4;
    localparam int PRESS_W = 16;
    // pressure words are signed hundredths of a psig
    localparam int PRESS_SCALE = 100;
    localparam int SETPOINT_PSIG = 3;
    localparam int ALLOWED_PSIG = 4;
    localparam int RANGE_MIN_PSIG = -15;
    localparam int RANGE_MAX_PSIG = 15;
    localparam logic signed [PRESS_W-1:0] SETPOINT_CNT =
        PRESS_W'(SETPOINT_PSIG * PRESS_SCALE);
    localparam logic signed [PRESS_W-1:0] ALLOWED_CNT =
        PRESS_W'(ALLOWED_PSIG * PRESS_SCALE);
    localparam logic signed [PRESS_W-1:0] RANGE_MIN_CNT =
        PRESS_W'(RANGE_MIN_PSIG * PRESS_SCALE);
    localparam logic signed [PRESS_W-1:0] RANGE_MAX_CNT =
        PRESS_W'(RANGE_MAX_PSIG * PRESS_SCALE);
    localparam int SYNC_STAGES = 3;
    // pin index map of the synchronised contact inputs
    localparam int PIN_TRIP0 = 0;
    localparam int PIN_TRIP1 = 1;
    localparam int PIN_RESET0 = 2;
    localparam int PIN_RESET1 = 3;
    localparam int PIN_CHECKBACK = 4;
    localparam int NUM_PINS = 5;
    localparam int CHAN_A = 0;
    localparam logic TRIP_RST = 1'h0;
    localparam logic ACT_RST = 1'h0;
    localparam logic PIN_RST = 1'h0;
    typedef logic signed [PRESS_W-1:0] bptv_press_t;
endpackage : bptv_pkg

//--- core/bptv_chan_if.sv
// link between the voter and one protective channel bistable
`timescale 1ns/1ps
`default_nettype none
interface bptv_chan_if;
    import bptv_pkg::*;
    bptv_press_t pressure;
    logic reset_req;
    logic above;
    logic tripped;
    modport voter (output pressure, output reset_req, input above, input tripped);
    modport chan (input pressure, input reset_req, output above, output tripped);
endinterface : bptv_chan_if
`default_nettype wire

//--- core/bptv_chan.sv
// one protective channel: setpoint comparator and latched trip
`timescale 1ns/1ps
`default_nettype none
module bptv_chan (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    bptv_chan_if.chan link
);
    import bptv_pkg::*;

    logic tripped;
    logic next_tripped;

    always_comb begin
        link.above = (link.pressure >= SETPOINT_CNT);
        // a new excursion wins over a reset in the same cycle
        next_tripped = tripped;
        if (link.above) begin
            next_tripped = 1'h1;
        end else if (link.reset_req) begin
            next_tripped = 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tripped <= TRIP_RST;
        end else begin
            tripped <= next_tripped;
        end
    end

    assign link.tripped = tripped;
endmodule : bptv_chan
`default_nettype wire

//--- verif/bptv_top_chk.sv
// port assertions for the pressure trip voter
`timescale 1ns/1ps
`default_nettype none
module bptv_top_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire bptv_pkg::bptv_press_t measured_building_pressure_i [bptv_pkg::NUM_CHAN],
    input wire logic [bptv_pkg::NUM_VOTED-1:0] manual_trip_pb_i,
    input wire logic [bptv_pkg::NUM_VOTED-1:0] building_cooling_initiation_o,
    input wire logic [bptv_pkg::NUM_OTHER-1:0] building_high_pressure_trip_o,
    input wire logic integrated_control_link_o,
    input wire logic [bptv_pkg::NUM_CHAN-1:0] chan_trip_status_o,
    input wire logic [bptv_pkg::NUM_CHAN-1:0] chan_bypass_status_o,
    input wire logic status_update_o,
    input wire logic odd_checkback_o,
    input wire logic even_checkback_o
);
    import bptv_pkg::*;
    logic [NUM_CHAN-1:0] hi;
    logic [NUM_CHAN-1:0] st;
    logic vote;
    assign st = chan_trip_status_o;
    assign vote = (st[0] & st[1]) | (st[0] & st[2]) | (st[1] & st[2]);
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            hi[i] = measured_building_pressure_i[i] >= SETPOINT_CNT;
        end
    end
    // keeps $past and $fell away from values sampled before reset acted
    logic armed;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            armed <= 1'h0;
        end else begin
            armed <= 1'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !armed);
    a_trip_sets: assert property (hi[0] |-> ##2 st[0])
        else $error("channel trip missing at setpoint");
    a_trip_holds: assert property ($fell(st[2]) |-> !$past(hi[2], 2))
        else $error("trip cleared while pressure high");
    a_vote_acts: assert property (vote |-> &building_cooling_initiation_o)
        else $error("two of three without actuation");
    a_other_req: assert property (building_high_pressure_trip_o == {NUM_OTHER{vote}})
        else $error("other channel request wrong");
    a_icl_chan_a: assert property (integrated_control_link_o == st[CHAN_A])
        else $error("degraded containment contact wrong");
    a_no_bypass: assert property (chan_bypass_status_o == '0)
        else $error("bypass status raised");
    a_update_pulse: assert property (status_update_o == (st != $past(st)))
        else $error("status update pulse wrong");
    a_checkback_pair: assert property (odd_checkback_o == even_checkback_o)
        else $error("checkback outputs differ");
    a_manual_trip: assert property (manual_trip_pb_i[0] [*6] |-> building_cooling_initiation_o[0])
        else $error("manual trip did not actuate");
endmodule : bptv_top_chk
bind bptv_top bptv_top_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .measured_building_pressure_i(measured_building_pressure_i),
    .manual_trip_pb_i(manual_trip_pb_i),
    .building_cooling_initiation_o(building_cooling_initiation_o),
    .building_high_pressure_trip_o(building_high_pressure_trip_o),
    .integrated_control_link_o(integrated_control_link_o),
    .chan_trip_status_o(chan_trip_status_o), .chan_bypass_status_o(chan_bypass_status_o),
    .status_update_o(status_update_o), .odd_checkback_o(odd_checkback_o),
    .even_checkback_o(even_checkback_o));
`default_nettype wire

//--- verif/bptv_field.sv
// pressure transmitter model, saturating at the ends of its span
`timescale 1ns/1ps
`default_nettype none
module bptv_field (
    input wire bptv_pkg::bptv_press_t target_i [bptv_pkg::NUM_CHAN],
    output var bptv_pkg::bptv_press_t pressure_o [bptv_pkg::NUM_CHAN]
);
    import bptv_pkg::*;
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (target_i[i] > RANGE_MAX_CNT) pressure_o[i] = RANGE_MAX_CNT;
            else if (target_i[i] < RANGE_MIN_CNT) pressure_o[i] = RANGE_MIN_CNT;
            else pressure_o[i] = target_i[i];
        end
    end
endmodule : bptv_field
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the pressure trip voter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bptv_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    bptv_press_t req [NUM_CHAN] = '{default: '0};
    bptv_press_t press [NUM_CHAN];
    logic [1:0] trip_pb = 2'h0;
    logic [1:0] reset_pb = 2'h0;
    logic chkbk = 1'b0;
    logic [1:0] cool;
    logic [3:0] other;
    logic icl, upd, odd, even;
    logic [2:0] st, byp, fault;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    bptv_field field (.target_i(req), .pressure_o(press));
    bptv_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .measured_building_pressure_i(press),
        .manual_trip_pb_i(trip_pb), .manual_reset_pb_i(reset_pb), .shared_checkback_i(chkbk),
        .building_cooling_initiation_o(cool), .building_high_pressure_trip_o(other),
        .integrated_control_link_o(icl), .chan_trip_status_o(st), .chan_bypass_status_o(byp),
        .sensor_range_fault_o(fault), .status_update_o(upd), .odd_checkback_o(odd),
        .even_checkback_o(even));
    task automatic close_out();
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_n
    task automatic press_pb(input logic [1:0] b, input logic trip);
        @(posedge clk_i);
        if (trip) trip_pb <= b;
        else reset_pb <= b;
        repeat (6) @(posedge clk_i);
        if (trip) trip_pb <= 2'h0;
        else reset_pb <= 2'h0;
        wait_n(6);
    endtask : press_pb
    task automatic t_single();
        chk("bypass", {5'h0, byp}, 8'h00);
        @(posedge clk_i);
        req[0] <= SETPOINT_CNT;
        req[1] <= SETPOINT_CNT - 16'sh0001;
        req[2] <= RANGE_MIN_CNT - 16'sh0064;
        wait_n(4);
        chk("status", {5'h0, st}, 8'h01);
        chk("range fault", {5'h0, fault}, 8'h00);
        chk("icl", {7'h0, icl}, 8'h01);
        chk("cooling", {6'h0, cool}, 8'h00);
    endtask : t_single
    task automatic t_vote();
        @(posedge clk_i);
        req[2] <= SETPOINT_CNT;
        wait_n(4);
        chk("cooling", {6'h0, cool}, 8'h03);
        chk("other", {4'h0, other}, 8'h0f);
        press_pb(2'h1, 1'b0);
        chk("held status", {5'h0, st}, 8'h05);
        @(posedge clk_i);
        req <= '{default: '0};
        press_pb(2'h2, 1'b0);
        chk("cleared status", {5'h0, st}, 8'h00);
        chk("cleared other", {4'h0, other}, 8'h00);
    endtask : t_vote
    task automatic t_manual();
        press_pb(2'h1, 1'b1);
        chk("manual cooling", {6'h0, cool}, 8'h01);
        chk("manual other", {4'h0, other}, 8'h00);
        press_pb(2'h1, 1'b0);
        chk("manual reset", {6'h0, cool}, 8'h00);
        @(posedge clk_i);
        chkbk <= 1'b1;
        wait_n(6);
        chk("checkback", {6'h0, odd, even}, 8'h03);
    endtask : t_manual
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_single();
        t_vote();
        t_manual();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
